// >>> design/mlsc_pkg.sv
// constants and carrier types for the loopback and start-of-packet control block
package mlsc_pkg;

    // ==========================================================
    // register map (printed offsets are word indices)
    localparam int unsigned ADDR_W = 18;
    localparam logic [15:0] LOOP_IDX = 16'h8055;
    localparam logic [15:0] SOP_IDX = 16'h805A;
    localparam logic [17:0] LOOP_ADDR = {LOOP_IDX, 2'h0};
    localparam logic [17:0] SOP_ADDR = {SOP_IDX, 2'h0};
    localparam logic [15:0] LOOP_RST = 16'h000A;
    localparam logic [15:0] SOP_RST = 16'h001B;

    // ==========================================================
    // loopback register fields
    localparam int unsigned LB_EN = 0;
    localparam int unsigned LB_TX_SUP = 1;
    localparam int unsigned REM_EN = 2;
    localparam int unsigned REM_RX_SUP = 3;
    localparam int unsigned LOOP_W = 4;

    // ==========================================================
    // start-of-packet register fields
    localparam int unsigned RX_SOP_EN = 0;
    localparam int unsigned RX_SOP_SFD = 1;
    localparam int unsigned RX_SOP_LEN = 2;
    localparam int unsigned TX_SOP_EN = 3;
    localparam int unsigned TX_SOP_SFD = 4;
    localparam int unsigned TX_SOP_LEN = 5;
    localparam int unsigned SOP_W = 6;

    // ==========================================================
    // frame constants
    localparam logic [7:0] SFD = 8'hD5;
    localparam logic [3:0] PRE_LEN = 4'h8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_W = 9;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } mlsc_tx_t;

    typedef struct packed {
        logic en;
        logic [7:0] data;
    } mlsc_byte_t;

    typedef struct packed {
        logic in_frame;
        logic sop;
        logic [3:0] cnt;
    } mlsc_trk_t;

    typedef struct packed {
        logic [LOOP_W-1:0] loop;
        logic [SOP_W-1:0] sopc;
        mlsc_byte_t phy_tx;
        mlsc_byte_t mac_rx;
        mlsc_trk_t [1:0] trk;
    } mlsc_st_t;

endpackage

// >>> design/mlsc_core.sv
// loopback routing, start-of-packet indication, transmit fifo and apb registers
// ==========================================================
// Overview of operation
// - local loopback bit set sends mac transmit bytes into the mac receive path while remote loopback is clear
// - with local loopback and transmit suppress set and remote loopback clear, nothing goes to the phy
// - remote loopback bit set sends phy receive bytes back out to the phy
// - with remote loopback and receive suppress set and local loopback clear, nothing reaches the mac
// - receive start indication appears only while its enable bit is set
// - receive start rises on delimiter when option set, else on first valid byte
// - receive start indication stays high until the frame ends
// - length check set raises receive start after eight bytes lacking a delimiter
// - transmit start indication appears only while its enable bit is set
// - delimiter option set raises transmit start on the outgoing delimiter
// - bit five applies the preamble length check to the transmit indication
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps

// ==========================================================
// fifo
module mlsc_fifo #(
    parameter int unsigned W = 9,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } mlsc_fifo_st_t;

    mlsc_fifo_st_t st_r;
    mlsc_fifo_st_t st_nxt;
    logic full;
    logic empty;

    // depth must be a power of two for the wrap bit to work
    assign full = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
    assign empty = st_r.wp == st_r.rp;
    // ready and valid drop with ce so no word moves while frozen
    assign in_ready = !full && ce;
    assign out_valid = !empty && ce;
    assign out_data = st_r.mem[st_r.rp[AW-1:0]];

    always_comb begin
        st_nxt = st_r;
        if (in_valid && in_ready) begin
            st_nxt.mem[st_r.wp[AW-1:0]] = in_data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end
endmodule

// ==========================================================
// top
module mlsc_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mac transmit
    input wire mlsc_pkg::mlsc_tx_t mac_tx,
    output logic mac_tx_ready,
    // phy transmit
    output mlsc_pkg::mlsc_byte_t phy_tx,
    input wire logic phy_tx_ready,
    // phy receive
    input wire mlsc_pkg::mlsc_byte_t phy_rx,
    // mac receive
    output mlsc_pkg::mlsc_byte_t mac_rx,
    // start-of-packet indications
    output logic rx_sop,
    output logic tx_sop
);
    mlsc_pkg::mlsc_st_t st_r;
    mlsc_pkg::mlsc_st_t st_nxt;
    logic fo_valid;
    logic fo_ready;
    logic [8:0] fo_data;
    logic lb;
    logic lb_sup;
    logic rem;
    logic rem_sup;
    logic fire;
    logic hit_loop;
    logic hit_sop;
    logic wr;
    logic [1:0] pb;
    logic [1:0] pe;
    logic [1:0] en;
    logic [1:0] osfd;
    logic [1:0] lchk;
    logic [1:0][7:0] pd;

    // ==========================================================
    // one step of a start-of-packet tracker
    function automatic mlsc_pkg::mlsc_trk_t trk_step(
        input mlsc_pkg::mlsc_trk_t t,
        input logic b,
        input logic [7:0] d,
        input logic e,
        input logic en_i,
        input logic osfd_i,
        input logic lchk_i
    );
        mlsc_pkg::mlsc_trk_t n;
        logic [3:0] cnt_now;
        n = t;
        cnt_now = t.in_frame ? t.cnt + 4'h1 : 4'h1;
        if (b) begin
            n.in_frame = 1'b1;
            // count saturates so a long preamble cannot wrap
            if (t.cnt != mlsc_pkg::PRE_LEN) begin
                n.cnt = cnt_now;
            end
            if (en_i && !osfd_i && !t.in_frame) begin
                n.sop = 1'b1;
            end
            if (en_i && osfd_i && d == mlsc_pkg::SFD) begin
                n.sop = 1'b1;
            end
            if (en_i && osfd_i && lchk_i && cnt_now == mlsc_pkg::PRE_LEN) begin
                n.sop = 1'b1;
            end
        end
        if (!en_i) begin
            n.sop = 1'b0;
        end
        if (e) begin
            n = '0;
        end
        return n;
    endfunction

    // ==========================================================
    // transmit fifo
    mlsc_fifo #(
        .W(mlsc_pkg::FIFO_W),
        .DEPTH(mlsc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .in_valid(mac_tx.valid),
        .in_ready(mac_tx_ready),
        .in_data({mac_tx.last, mac_tx.data}),
        .out_valid(fo_valid),
        .out_ready(fo_ready),
        .out_data(fo_data)
    );

    assign lb = st_r.loop[mlsc_pkg::LB_EN];
    assign lb_sup = st_r.loop[mlsc_pkg::LB_TX_SUP];
    assign rem = st_r.loop[mlsc_pkg::REM_EN];
    assign rem_sup = st_r.loop[mlsc_pkg::REM_RX_SUP];
    // remote loopback owns the phy transmit side, so mac bytes wait in the fifo
    // a suppressed local loop does not need the phy, so its stall is ignored
    assign fo_ready = !rem && (phy_tx_ready || (lb && lb_sup));
    assign fire = fo_valid && fo_ready;

    // ==========================================================
    // apb slave: zero wait states, frozen with ce
    assign hit_loop = paddr == mlsc_pkg::LOOP_ADDR;
    assign hit_sop = paddr == mlsc_pkg::SOP_ADDR;
    assign wr = psel && penable && pwrite && ce;
    assign pready = ce;
    assign pslverr = psel && penable && !hit_loop && !hit_sop;
    assign prdata = !psel ? 32'h0000_0000 :
                    hit_loop ? 32'(st_r.loop) :
                    hit_sop ? 32'(st_r.sopc) : 32'h0000_0000;

    assign phy_tx = st_r.phy_tx;
    assign mac_rx = st_r.mac_rx;
    assign rx_sop = st_r.trk[0].sop;
    assign tx_sop = st_r.trk[1].sop;

    // ==========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        // register writes, only lane 0 holds defined bits
        if (wr && hit_loop && pstrb[0]) begin
            st_nxt.loop = pwdata[mlsc_pkg::LOOP_W-1:0];
        end else if (wr && hit_sop && pstrb[0]) begin
            st_nxt.sopc = pwdata[mlsc_pkg::SOP_W-1:0];
        end
        if (rem) begin
            st_nxt.phy_tx = phy_rx;
        end else if (lb && lb_sup) begin
            st_nxt.phy_tx = '0;
        end else begin
            st_nxt.phy_tx = {fire, fo_data[7:0]};
        end
        if (lb) begin
            st_nxt.mac_rx = {fire, fo_data[7:0]};
        end else if (rem && rem_sup) begin
            st_nxt.mac_rx = '0;
        end else begin
            st_nxt.mac_rx = phy_rx;
        end
        // receive tracker follows the mac-bound stream
        if (lb) begin
            pb[0] = fire;
            pd[0] = fo_data[7:0];
            pe[0] = fire && fo_data[8];
        end else if (rem && rem_sup) begin
            pb[0] = 1'b0;
            pd[0] = phy_rx.data;
            pe[0] = st_r.trk[0].in_frame;
        end else begin
            pb[0] = phy_rx.en;
            pd[0] = phy_rx.data;
            pe[0] = st_r.trk[0].in_frame && !phy_rx.en;
        end
        en[0] = st_r.sopc[mlsc_pkg::RX_SOP_EN];
        osfd[0] = st_r.sopc[mlsc_pkg::RX_SOP_SFD];
        lchk[0] = st_r.sopc[mlsc_pkg::RX_SOP_LEN];
        // transmit tracker follows outgoing mac bytes
        pb[1] = fire;
        pd[1] = fo_data[7:0];
        pe[1] = fire && fo_data[8];
        en[1] = st_r.sopc[mlsc_pkg::TX_SOP_EN];
        osfd[1] = st_r.sopc[mlsc_pkg::TX_SOP_SFD];
        lchk[1] = st_r.sopc[mlsc_pkg::TX_SOP_LEN];
        for (int i = 0; i < 2; i++) begin
            st_nxt.trk[i] = trk_step(st_r.trk[i], pb[i], pd[i], pe[i],
                                     en[i], osfd[i], lchk[i]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.loop <= mlsc_pkg::LOOP_RST[mlsc_pkg::LOOP_W-1:0];
            st_r.sopc <= mlsc_pkg::SOP_RST[mlsc_pkg::SOP_W-1:0];
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rx_sfd_s;
        ce && en[0] && osfd[0] && pb[0] && !pe[0] && pd[0] == mlsc_pkg::SFD;
    endsequence

    sequence tx_sfd_s;
        ce && en[1] && osfd[1] && pb[1] && !pe[1] && pd[1] == mlsc_pkg::SFD;
    endsequence

    sequence rx_eighth_s;
        ce && en[0] && osfd[0] && lchk[0] && pb[0] && !pe[0]
            && st_r.trk[0].in_frame && st_r.trk[0].cnt == 4'h7;
    endsequence

    sequence tx_eighth_s;
        ce && en[1] && osfd[1] && lchk[1] && pb[1] && !pe[1]
            && st_r.trk[1].in_frame && st_r.trk[1].cnt == 4'h7;
    endsequence

    local_route_a: assert property (ce && lb && fire |=>
        mac_rx.en && mac_rx.data == $past(fo_data[7:0]))
        else $error("local loopback byte not seen at mac receive");

    tx_suppress_a: assert property (ce && lb && lb_sup && !rem |=> !phy_tx.en)
        else $error("suppressed loopback byte reached phy");

    remote_route_a: assert property (ce && rem && phy_rx.en |=>
        phy_tx.en && phy_tx.data == $past(phy_rx.data))
        else $error("remote loopback byte not sent to phy");

    rx_block_a: assert property (ce && rem && rem_sup && !lb |=> !mac_rx.en)
        else $error("suppressed receive byte reached mac");

    rx_gate_a: assert property (ce && !en[0] |=> !rx_sop)
        else $error("receive start high while disabled");

    rx_sfd_a: assert property (rx_sfd_s |=> rx_sop)
        else $error("receive start missed on delimiter");

    rx_hold_a: assert property (rx_sop && ce && en[0] && !pe[0] |=> rx_sop)
        else $error("receive start dropped inside frame");

    rx_len_a: assert property (rx_eighth_s |=> rx_sop)
        else $error("receive start missing after eighth byte");

    rx_nolen_a: assert property (ce && !lchk[0] && osfd[0] && !rx_sop && pb[0]
        && pd[0] != mlsc_pkg::SFD |=> !rx_sop)
        else $error("receive start raised without delimiter");

    tx_gate_a: assert property (ce && !en[1] |=> !tx_sop)
        else $error("transmit start high while disabled");

    tx_sfd_a: assert property (tx_sfd_s |=> tx_sop)
        else $error("transmit start missed on delimiter");

    tx_len_a: assert property (tx_eighth_s |=> tx_sop)
        else $error("transmit start missing after eighth byte");

    tx_hold_a: assert property (tx_sop && ce && en[1] && !pe[1] |=> tx_sop)
        else $error("transmit start dropped inside frame");
endmodule

// >>> test/mlsc_phy_model.sv
// far-side phy model: stalling sink that counts transmitted bytes
`timescale 1ns/1ps
module mlsc_phy_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // phy transmit
    input wire mlsc_pkg::mlsc_byte_t phy_tx,
    output logic phy_tx_ready,
    // observation
    output int n_got,
    output logic [7:0] last_got
);
    logic [1:0] ph_r;
    // ==========================================================
    // sink
    // ready one cycle in three, so the fifo drain stalls two cycles of every three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= 2'h0;
            n_got <= 0;
            last_got <= 8'h00;
        end else begin
            ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
            if (phy_tx.en) begin
                n_got <= n_got + 1;
                last_got <= phy_tx.data;
            end
        end
    end
    assign phy_tx_ready = (ph_r == 2'h0);
endmodule

// >>> test/mlsc_core_bench.sv
// self-checking bench: registers, loopback routing, start indications, fifo
`timescale 1ns/1ps
module mlsc_core_bench;
    typedef struct packed {
        logic [15:0] loop;
        logic [15:0] sopc;
        logic [3:0] nb;
        logic [3:0] sfd;
        logic [3:0] rise;
        logic [4:0] fl;
        logic [1:0] txs;
    } mlsc_row_t;
    // fl: rx to mac, rx to phy, send tx frame, tx to phy, tx to mac; txs 2 = skip
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, mac_tx_ready, phy_tx_ready, rx_sop, tx_sop, ok;
    logic tsop_seen = 1'b0;
    logic [7:0] last_got;
    mlsc_pkg::mlsc_tx_t mac_tx = '0;
    mlsc_pkg::mlsc_byte_t phy_rx = '0;
    mlsc_pkg::mlsc_byte_t phy_tx, mac_rx;
    int bad_count = 0;
    int n_compared = 0;
    int n_mrx = 0;
    int n_got, n0, i, r;
    mlsc_row_t rows[10];

    always #12.5 pclk = ~pclk;

    mlsc_core u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mac_tx(mac_tx), .mac_tx_ready(mac_tx_ready), .phy_tx(phy_tx),
        .phy_tx_ready(phy_tx_ready), .phy_rx(phy_rx), .mac_rx(mac_rx),
        .rx_sop(rx_sop), .tx_sop(tx_sop));
    mlsc_phy_model u_phy (.pclk(pclk), .presetn(presetn), .phy_tx(phy_tx),
        .phy_tx_ready(phy_tx_ready), .n_got(n_got), .last_got(last_got));

    always @(posedge pclk) begin
        if (mac_rx.en === 1'b1) n_mrx++;
        if (tx_sop === 1'b1) tsop_seen = 1'b1;
    end

    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // only the watchdog ends a wait for pready
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // entered at a rising edge; leaves at the edge that took the byte
    task automatic send_tx(input logic [7:0] d, input logic l);
        mac_tx <= {1'b1, l, d};
        ok = 1'b0;
        while (!ok) begin
            @(negedge pclk);
            ok = (mac_tx_ready === 1'b1);
            @(posedge pclk);
        end
    endtask

    task automatic test_done;
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        #1000000;
        bad_count++;
        test_done();
    end

    // ==========================================================
    // main sequence
    initial begin
        rows = '{'{16'h0, 16'h1B, 4'h8, 4'h6, 4'h6, 5'h16, 2'h1},
            '{16'h1, 16'h1B, 4'h8, 4'h6, 4'hF, 5'h07, 2'h1},
            '{16'h3, 16'h1B, 4'h8, 4'h6, 4'hF, 5'h05, 2'h2},
            '{16'h4, 16'h1B, 4'h8, 4'h6, 4'h6, 5'h18, 2'h2},
            '{16'hC, 16'h1B, 4'h8, 4'h6, 4'hF, 5'h08, 2'h2},
            '{16'h0, 16'h19, 4'h8, 4'h6, 4'h0, 5'h16, 2'h1},
            '{16'h0, 16'h1F, 4'hA, 4'hF, 4'h7, 5'h10, 2'h2},
            '{16'h0, 16'h1B, 4'hA, 4'hF, 4'hF, 5'h10, 2'h2},
            '{16'h0, 16'h12, 4'h8, 4'h6, 4'hF, 5'h16, 2'h0},
            '{16'h0, 16'h1F, 4'h8, 4'h3, 4'h3, 5'h10, 2'h2}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (r = 0; r < 10; r++) begin
            apb(1'b1, mlsc_pkg::LOOP_ADDR, {16'h0, rows[r].loop});
            apb(1'b1, mlsc_pkg::SOP_ADDR, {16'h0, rows[r].sopc});
            for (i = 0; i <= rows[r].nb; i++) begin
                @(posedge pclk);
                phy_rx <= (i == rows[r].nb) ? '0 :
                    {1'b1, (i == rows[r].sfd) ? 8'hD5 : 8'h55};
                @(negedge pclk);
                if (i > 0)
                    chk({mac_rx.en, phy_tx.en, rx_sop}, {rows[r].fl[4:3],
                        1'(i - 1 >= rows[r].rise)});
            end
            repeat (3) @(negedge pclk);
            chk(rx_sop, 1'b0);
            if (rows[r].fl[2]) begin
                n_mrx = 0;
                tsop_seen = 1'b0;
                n0 = n_got;
                @(posedge pclk);
                for (i = 0; i < 4; i++)
                    send_tx((i == 2) ? 8'hD5 : 8'h55, i == 3);
                mac_tx <= '0;
                repeat (24) @(negedge pclk);
                chk(n_got - n0, rows[r].fl[1] ? 4 : 0);
                chk(n_mrx, rows[r].fl[0] ? 4 : 0);
                if (rows[r].txs != 2'h2) chk(tsop_seen, rows[r].txs[0]);
            end
        end
        // fifo fills while remote loopback holds it, then drains into a slow sink
        apb(1'b1, mlsc_pkg::LOOP_ADDR, 32'h4);
        n0 = n_got;
        @(posedge pclk);
        for (i = 0; i < 8; i++) send_tx(8'(i + 16), i == 7);
        mac_tx <= '0;
        chk(ok, 1'b1);
        @(negedge pclk);
        chk({mac_tx_ready, 8'(n_got - n0)}, 9'h000);
        apb(1'b1, mlsc_pkg::LOOP_ADDR, 32'h0);
        repeat (40) @(negedge pclk);
        chk({last_got, 8'(n_got - n0)}, 16'h1708);
        // reserved bits, unmapped address, then a mid-run reset
        apb(1'b1, mlsc_pkg::LOOP_ADDR, 32'hFFFF);
        apb(1'b0, mlsc_pkg::LOOP_ADDR, 32'h0);
        chk(rd, 32'hF);
        apb(1'b0, 18'h00100, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h00000000);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, mlsc_pkg::LOOP_ADDR, 32'h0);
        chk(rd, 32'h0000000A);
        apb(1'b0, mlsc_pkg::SOP_ADDR, 32'h0);
        chk(rd, 32'h0000001B);
        // transmit frame of ten bytes with no delimiter, length check on then off
        for (r = 0; r < 2; r++) begin
            apb(1'b1, mlsc_pkg::SOP_ADDR, (r == 0) ? 32'h38 : 32'h18);
            tsop_seen = 1'b0;
            n0 = n_got;
            @(posedge pclk);
            for (i = 0; i < 10; i++) send_tx(8'h55, i == 9);
            mac_tx <= '0;
            repeat (40) @(negedge pclk);
            chk(n_got - n0, 10);
            chk(tsop_seen, r == 0);
        end
        // clock enable low freezes state and refuses both handshakes
        @(posedge pclk);
        ce <= 1'b0;
        phy_rx <= {1'b1, 8'hD5};
        repeat (3) @(negedge pclk);
        chk({pready, mac_tx_ready, mac_rx.en}, 3'h0);
        @(posedge pclk);
        ce <= 1'b1;
        @(posedge pclk);
        phy_rx <= '0;
        @(negedge pclk);
        chk({mac_rx.en, mac_rx.data}, 9'h1D5);
        test_done();
    end
endmodule
